// *** rtl/ess_stats_map.vh ***
`ifndef ESS_STATS_MAP_VH
`define ESS_STATS_MAP_VH

// Register indices of the statistics page
`define ESS_IDX_STATUS 7'h02
`define ESS_IDX_ROW 7'h04
`define ESS_IDX_LEFT 7'h05
`define ESS_IDX_RIGHT 7'h06
`define ESS_IDX_FRAME 7'h07
`define ESS_IDX_ZONE1 7'h08
`define ESS_IDX_ZONE2 7'h09
`define ESS_IDX_ZONE3 7'h0a
`define ESS_IDX_ZONE4 7'h0b

// Indices of the deferred exposure page registers
`define ESS_IDX_FINE 7'h21
`define ESS_IDX_COARSE 7'h23
`define ESS_IDX_GAIN 7'h24
`define ESS_IDX_CLKDIV 7'h25

// Status bit positions
`define ESS_ST_EXP 0
`define ESS_ST_CLKDIV 1
`define ESS_ST_GAIN 2
`define ESS_ST_ODD 3
`define ESS_ST_CALFAIL 4

// Reset values
`define ESS_RST_STAT 8'h00
`define ESS_RST_FINE 8'h00
`define ESS_RST_COARSE 8'h70
`define ESS_RST_GAIN 8'h00
`define ESS_RST_CLKDIV 8'h00

// Video timing: 256 pixel clocks a line, 256 lines a frame
`define ESS_CNT_MAX 8'hff
`define ESS_ACT_PIX 8'ha0
`define ESS_HALF_PIX 8'h50
`define ESS_ACT_LINES 8'h78
`define ESS_BIN_LINES 8'h1e

// Divisors for the averages
`define ESS_HALF_DIV 15'h0050
`define ESS_BIN_DIV 14'h003c
`define ESS_FRAME_DIV 16'h00f0

`endif

// *** rtl/ess_gray_counter.v ***
`include "ess_stats_map.vh"

module ess_gray_counter (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Count control
    input wire advance,
    // Count outputs
    output reg [7:0] grayCount_q,
    output wire [7:0] binCount,
    output wire wrap
);

    // Gray to binary by running XOR from the top bit
    function [7:0] grayToBin;
        input [7:0] g;
        integer i;
        begin
            grayToBin[7] = g[7];
            for (i = 6; i >= 0; i = i - 1) begin
                grayToBin[i] = grayToBin[i + 1] ^ g[i];
            end
        end
    endfunction

    wire [7:0] nextBin;
    wire [7:0] grayCount_d;

    // Full 2^8 period keeps even the wrap a one-bit change
    assign binCount = grayToBin(grayCount_q);
    assign nextBin = binCount + 8'h01;
    assign grayCount_d = nextBin ^ {1'b0, nextBin[7:1]};
    assign wrap = advance && (binCount == `ESS_CNT_MAX);

    // Only the gray code is stored; binary is derived
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            grayCount_q <= 8'h00;
        end else if (advance) begin
            grayCount_q <= grayCount_d;
        end
    end

endmodule // ess_gray_counter

// *** rtl/ess_half_mean.v ***
`include "ess_stats_map.vh"

module ess_half_mean (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Pixel stream
    input wire addEn,
    input wire firstPix,
    input wire lastPix,
    input wire [7:0] pixel,
    // Latched mean
    output reg [7:0] mean_q
);

    reg [14:0] sum_q;
    wire [14:0] sumNext;
    wire [14:0] quotient;

    // First pixel restarts the sum so no clear cycle is needed
    assign sumNext = firstPix ? {7'h00, pixel} : sum_q + {7'h00, pixel};
    assign quotient = sumNext / `ESS_HALF_DIV;

    // Sum and latch; latch holds until the next half completes
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sum_q <= 15'h0000;
            mean_q <= 8'h00;
        end else if (addEn) begin
            sum_q <= sumNext;
            if (lastPix) begin
                mean_q <= quotient[7:0];
            end
        end
    end

endmodule // ess_half_mean

// *** rtl/ess_stats_top.v ***
`include "ess_stats_map.vh"

// Function
// - New exposure values wait for a frame start; gain and clock division do too unless their immediate option is on.
// - Status bit 0 flags an exposure write until the controller takes it.
// - Status bit 1 flags a clock division write until it is taken.
// - Status bit 2 flags a gain write until it is taken.
// - Status bit 3 toggles at every new frame and resets to zero.
// - Status bit 4 sets on a failed black calibration until one passes.
// - Pixel and line counters run in gray code, one bit change a clock.
// - The line count is converted to binary and only binary is read.
// - The row register shows the binary line number in bits 7 to 0.
// - Qualified left half pixels are summed and the mean is latched.
// - The right half is then summed and latched separately.
// - Each half mean stays valid until its own next latch; right lags left.
// - Each active line adds both half means into a running bin sum.
// - At frame end the bins give the previous frame mean.
// - Four zone mean registers at indices 8 to 11 reset to zero.
module ess_stats_top (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Register access from the serial slave
    input wire [6:0] regIndex,
    input wire regWrEn,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData_q,
    // Immediate update options
    input wire immGainEn,
    input wire immClkDivEn,
    // Pixel data from the converter
    input wire [7:0] pixelData,
    // Black calibration result
    input wire calDone,
    input wire calInWindow,
    // Video timing
    output wire [7:0] grayPixel,
    output wire [7:0] grayLine,
    output reg frameStart_q,
    // Settings in force
    output reg [7:0] appliedFine_q,
    output reg [7:0] appliedCoarse_q,
    output reg [7:0] appliedGain_q,
    output reg [7:0] appliedClkDiv_q
);

    // Map an active line number to its zone
    function [1:0] zoneOf;
        input [7:0] line;
        begin
            if (line < `ESS_BIN_LINES) begin
                zoneOf = 2'h0;
            end else if (line < (`ESS_BIN_LINES + `ESS_BIN_LINES)) begin
                zoneOf = 2'h1;
            end else if (line < (`ESS_ACT_LINES - `ESS_BIN_LINES)) begin
                zoneOf = 2'h2;
            end else begin
                zoneOf = 2'h3;
            end
        end
    endfunction

    // Zone mean from one bin sum; the divide truncates
    function [7:0] zoneMeanOf;
        input [13:0] s;
        reg [13:0] q;
        begin
            q = s / `ESS_BIN_DIV;
            zoneMeanOf = q[7:0];
        end
    endfunction

    wire [7:0] pixBin;
    wire [7:0] lineBin;
    wire pixWrap;
    wire lineWrap;
    wire activeLine;
    wire leftAdd;
    wire rightAdd;
    wire lineEnd;
    wire frameEnd;
    wire [7:0] leftMean;
    wire [7:0] rightMean;
    wire wrFine;
    wire wrCoarse;
    wire wrGain;
    wire wrClkDiv;
    wire [7:0] status;
    wire [8:0] lineSum;
    wire [15:0] frameSum;
    wire [15:0] frameQuot;
    wire [1:0] curZone;
    reg [7:0] pendFine_q;
    reg [7:0] pendCoarse_q;
    reg [7:0] pendGain_q;
    reg [7:0] pendClkDiv_q;
    reg expPend_q;
    reg clkDivPend_q;
    reg gainPend_q;
    reg oddFrame_q;
    reg calFail_q;
    reg [13:0] binSum_q [0:3];
    reg [7:0] zoneMean_q [0:3];
    reg [7:0] frameMean_q;
    reg [7:0] rdData_d;
    integer z;

    // Pixel counter free runs; line counter steps at pixel wrap
    ess_gray_counter u_pixCnt (
        .clk(clk),
        .nrst(nrst),
        .advance(1'b1),
        .grayCount_q(grayPixel),
        .binCount(pixBin),
        .wrap(pixWrap)
    );

    ess_gray_counter u_lineCnt (
        .clk(clk),
        .nrst(nrst),
        .advance(pixWrap),
        .grayCount_q(grayLine),
        .binCount(lineBin),
        .wrap(lineWrap)
    );

    // Qualified window decode within each line
    assign activeLine = lineBin < `ESS_ACT_LINES;
    assign leftAdd = activeLine && (pixBin < `ESS_HALF_PIX);
    assign rightAdd = activeLine && (pixBin >= `ESS_HALF_PIX) &&
        (pixBin < `ESS_ACT_PIX);
    assign lineEnd = activeLine && (pixBin == `ESS_ACT_PIX);
    assign frameEnd = (lineBin == `ESS_ACT_LINES) && (pixBin == 8'h00);

    // Left half mean latched on its last pixel
    ess_half_mean u_leftMean (
        .clk(clk),
        .nrst(nrst),
        .addEn(leftAdd),
        .firstPix(pixBin == 8'h00),
        .lastPix(pixBin == (`ESS_HALF_PIX - 8'h01)),
        .pixel(pixelData),
        .mean_q(leftMean)
    );

    // Right half mean, a separate latch over the same line
    ess_half_mean u_rightMean (
        .clk(clk),
        .nrst(nrst),
        .addEn(rightAdd),
        .firstPix(pixBin == `ESS_HALF_PIX),
        .lastPix(pixBin == (`ESS_ACT_PIX - 8'h01)),
        .pixel(pixelData),
        .mean_q(rightMean)
    );

    // Register write decode of the deferred settings
    assign wrFine = regWrEn && (regIndex == `ESS_IDX_FINE);
    assign wrCoarse = regWrEn && (regIndex == `ESS_IDX_COARSE);
    assign wrGain = regWrEn && (regIndex == `ESS_IDX_GAIN);
    assign wrClkDiv = regWrEn && (regIndex == `ESS_IDX_CLKDIV);

    // Pending exposure; a write at frame start stays pending
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pendFine_q <= `ESS_RST_FINE;
            pendCoarse_q <= `ESS_RST_COARSE;
            appliedFine_q <= `ESS_RST_FINE;
            appliedCoarse_q <= `ESS_RST_COARSE;
            expPend_q <= 1'b0;
        end else begin
            if (lineWrap && expPend_q) begin
                appliedFine_q <= pendFine_q;
                appliedCoarse_q <= pendCoarse_q;
            end
            if (wrFine) begin
                pendFine_q <= regWrData;
            end
            if (wrCoarse) begin
                pendCoarse_q <= regWrData;
            end
            // Set wins over the frame start clear
            if (wrFine || wrCoarse) begin
                expPend_q <= 1'b1;
            end else if (lineWrap) begin
                expPend_q <= 1'b0;
            end
        end
    end

    // Pending gain, or taken at once when the immediate option is on
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pendGain_q <= `ESS_RST_GAIN;
            appliedGain_q <= `ESS_RST_GAIN;
            gainPend_q <= 1'b0;
        end else begin
            if (wrGain && immGainEn) begin
                appliedGain_q <= regWrData;
            end else if (lineWrap && gainPend_q) begin
                appliedGain_q <= pendGain_q;
            end
            if (wrGain) begin
                pendGain_q <= regWrData;
            end
            if (wrGain && !immGainEn) begin
                gainPend_q <= 1'b1;
            end else if (lineWrap || (wrGain && immGainEn)) begin
                gainPend_q <= 1'b0;
            end
        end
    end

    // Pending clock division, same scheme as gain
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pendClkDiv_q <= `ESS_RST_CLKDIV;
            appliedClkDiv_q <= `ESS_RST_CLKDIV;
            clkDivPend_q <= 1'b0;
        end else begin
            if (wrClkDiv && immClkDivEn) begin
                appliedClkDiv_q <= regWrData;
            end else if (lineWrap && clkDivPend_q) begin
                appliedClkDiv_q <= pendClkDiv_q;
            end
            if (wrClkDiv) begin
                pendClkDiv_q <= regWrData;
            end
            if (wrClkDiv && !immClkDivEn) begin
                clkDivPend_q <= 1'b1;
            end else if (lineWrap || (wrClkDiv && immClkDivEn)) begin
                clkDivPend_q <= 1'b0;
            end
        end
    end

    // Frame parity and the frame start marker
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oddFrame_q <= 1'b0;
            frameStart_q <= 1'b0;
        end else begin
            frameStart_q <= lineWrap;
            if (lineWrap) begin
                oddFrame_q <= ~oddFrame_q;
            end
        end
    end

    // Calibration fail is sticky until a passing calibration
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            calFail_q <= 1'b0;
        end else if (calDone) begin
            calFail_q <= ~calInWindow;
        end
    end

    // Both latched half means of the finished line
    assign lineSum = {1'b0, leftMean} + {1'b0, rightMean};
    assign curZone = zoneOf(lineBin);
    assign frameSum = {2'b00, binSum_q[0]} + {2'b00, binSum_q[1]} +
        {2'b00, binSum_q[2]} + {2'b00, binSum_q[3]};
    assign frameQuot = frameSum / `ESS_FRAME_DIV;

    // Zone sums; one line end cycle after the right latch
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (z = 0; z < 4; z = z + 1) begin
                binSum_q[z] <= 14'h0000;
                zoneMean_q[z] <= 8'h00;
            end
            frameMean_q <= 8'h00;
        end else if (lineEnd) begin
            binSum_q[curZone] <= binSum_q[curZone] +
                {5'h00, lineSum};
        end else if (frameEnd) begin
            // Divide and restart the bins in one cycle
            for (z = 0; z < 4; z = z + 1) begin
                zoneMean_q[z] <= zoneMeanOf(binSum_q[z]);
                binSum_q[z] <= 14'h0000;
            end
            frameMean_q <= frameQuot[7:0];
        end
    end

    // Status byte; top three bits are unused
    assign status = {3'b000, calFail_q, oddFrame_q, gainPend_q,
        clkDivPend_q, expPend_q};

    // Read mux; writes never reach any statistics register
    always @* begin
        case (regIndex)
            `ESS_IDX_STATUS: rdData_d = status;
            `ESS_IDX_ROW: rdData_d = lineBin;
            `ESS_IDX_LEFT: rdData_d = leftMean;
            `ESS_IDX_RIGHT: rdData_d = rightMean;
            `ESS_IDX_FRAME: rdData_d = frameMean_q;
            `ESS_IDX_ZONE1: rdData_d = zoneMean_q[0];
            `ESS_IDX_ZONE2: rdData_d = zoneMean_q[1];
            `ESS_IDX_ZONE3: rdData_d = zoneMean_q[2];
            `ESS_IDX_ZONE4: rdData_d = zoneMean_q[3];
            default: rdData_d = 8'h00;
        endcase
    end

    // Registered read data, one cycle behind the index
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData_q <= 8'h00;
        end else begin
            regRdData_q <= rdData_d;
        end
    end

endmodule // ess_stats_top

// *** testbench/ess_stats_properties.sv ***
module ess_stats_properties (
    // Clock and reset
    input clk,
    input nrst,
    // Register access
    input [6:0] regIndex,
    input regWrEn,
    input [7:0] regWrData,
    input [7:0] regRdData_q,
    // Options, converter, calibration
    input immGainEn,
    input immClkDivEn,
    input [7:0] pixelData,
    input calDone,
    input calInWindow,
    // Timing and settings in force
    input [7:0] grayPixel,
    input [7:0] grayLine,
    input frameStart_q,
    input [7:0] appliedFine_q,
    input [7:0] appliedCoarse_q,
    input [7:0] appliedGain_q,
    input [7:0] appliedClkDiv_q
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    status_top_zero_a: assert property (regIndex == 7'h02
        |=> regRdData_q[7:5] == 3'h0) else $error("status top bits set");
    unmapped_zero_a: assert property (regIndex == 7'h03
        |=> regRdData_q == 8'h00) else $error("unmapped read not zero");
    pixel_gray_a: assert property (
        $countones(grayPixel ^ $past(grayPixel)) <= 1)
        else $error("pixel count moved several bits");
    line_gray_a: assert property (
        $countones(grayLine ^ $past(grayLine)) <= 1)
        else $error("line count moved several bits");
    frame_pulse_a: assert property (frameStart_q
        |-> grayLine == 8'h00 ##1 !frameStart_q)
        else $error("frame start pulse misplaced");
    // Settings may only move at a frame start or after an immediate write
    gain_defer_a: assert property ($changed(appliedGain_q)
        |-> frameStart_q || $past(regWrEn && immGainEn)
        || $past(regWrEn && immGainEn, 2)) else $error("gain moved mid frame");
    clkdiv_defer_a: assert property ($changed(appliedClkDiv_q)
        |-> frameStart_q || $past(regWrEn && immClkDivEn)
        || $past(regWrEn && immClkDivEn, 2))
        else $error("clock division moved mid frame");
    fine_defer_a: assert property ($changed(appliedFine_q)
        |-> frameStart_q) else $error("fine moved mid frame");
    coarse_defer_a: assert property ($changed(appliedCoarse_q)
        |-> frameStart_q) else $error("coarse moved mid frame");
endmodule // ess_stats_properties

bind ess_stats_top ess_stats_properties ess_stats_properties_inst (
    .clk(clk), .nrst(nrst), .regIndex(regIndex), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData_q(regRdData_q),
    .immGainEn(immGainEn), .immClkDivEn(immClkDivEn),
    .pixelData(pixelData), .calDone(calDone), .calInWindow(calInWindow),
    .grayPixel(grayPixel), .grayLine(grayLine),
    .frameStart_q(frameStart_q), .appliedFine_q(appliedFine_q),
    .appliedCoarse_q(appliedCoarse_q), .appliedGain_q(appliedGain_q),
    .appliedClkDiv_q(appliedClkDiv_q));

// *** testbench/ess_host_model.sv ***
module ess_host_model (
    // Clock
    input clk,
    // Register bus toward the sensor
    output logic [6:0] regIndex,
    output logic regWrEn,
    output logic [7:0] regWrData,
    input [7:0] regRdData_q
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        regIndex = 7'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
    end

    // One byte write; data inverted once released so stale data never helps
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        @(negedge clk);
        regIndex = i;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask

    // Polling read: index taken at one edge, byte shown after it
    task automatic rd(input logic [6:0] i, output logic [7:0] d);
        @(negedge clk);
        regIndex = i;
        @(negedge clk);
        d = regRdData_q;
    endtask
endmodule // ess_host_model

// *** testbench/tb_ess_stats_top.sv ***
module tb_ess_stats_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, immGainEn, immClkDivEn, calDone, calInWindow;
    logic regWrEn, frameStart_q;
    logic [6:0] regIndex;
    logic [7:0] regWrData, regRdData_q, pixelData, grayPixel, grayLine, v;
    logic [7:0] aFine, aCoarse, aGain, aClkDiv;
    int cyc, n_fail, n_compared, i;

    ess_stats_top ess_stats_top_inst (.clk(clk), .nrst(nrst),
        .regIndex(regIndex), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdData_q(regRdData_q), .immGainEn(immGainEn),
        .immClkDivEn(immClkDivEn), .pixelData(pixelData),
        .calDone(calDone), .calInWindow(calInWindow),
        .grayPixel(grayPixel), .grayLine(grayLine),
        .frameStart_q(frameStart_q), .appliedFine_q(aFine),
        .appliedCoarse_q(aCoarse), .appliedGain_q(aGain),
        .appliedClkDiv_q(aClkDiv));
    ess_host_model ess_host_model_inst (.clk(clk), .regIndex(regIndex),
        .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdData_q(regRdData_q));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Edges since release; one frame is 65536 so the guard sits just past
    always @(posedge clk) begin
        if (nrst) cyc <= cyc + 1;
        if (cyc > 70000) begin
            n_fail++;
            wrap_up;
        end
    end

    // Flat value per line, switched in blanking so alignment never matters
    function automatic logic [7:0] zv(input int l);
        if (l % 256 >= 120) return 8'h00;
        return 8'(32 * (l % 256 / 30 + 1));
    endfunction
    always @(negedge clk) pixelData <= zv((cyc + 56) / 256);

    task automatic chk(input string nm, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        ess_host_model_inst.rd(a, v);
        chk($sformatf("index %h", a), v, e);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        ess_host_model_inst.wr(a, d);
    endtask
    task automatic cal(input logic pass);
        @(negedge clk);
        calDone = 1'b1;
        calInWindow = pass;
        @(negedge clk);
        calDone = 1'b0;
        calInWindow = ~pass;
    endtask
    task automatic wrap_up;
        $display("Compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        immGainEn = 1'b0;
        immClkDivEn = 1'b0;
        calDone = 1'b0;
        calInWindow = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        for (i = 2; i < 12; i++) rchk(7'(i), 8'h00);
        wr(7'h05, 8'hff);
        rchk(7'h05, 8'h00);
        // Immediate updates skip the pending flags
        immGainEn = 1'b1;
        immClkDivEn = 1'b1;
        wr(7'h24, 8'h11);
        wr(7'h25, 8'h03);
        @(negedge clk);
        immGainEn = 1'b0;
        immClkDivEn = 1'b0;
        chk("gain", aGain, 8'h11);
        chk("clkdiv", aClkDiv, 8'h03);
        rchk(7'h02, 8'h00);
        // Deferred writes wait for the frame start
        wr(7'h24, 8'h5a);
        wr(7'h25, 8'h06);
        wr(7'h21, 8'h33);
        wr(7'h23, 8'h44);
        rchk(7'h02, 8'h07);
        chk("coarse", aCoarse, 8'h70);
        cal(1'b0);
        rchk(7'h02, 8'h17);
        cal(1'b1);
        rchk(7'h02, 8'h07);
        // Line 30: left from this line, right still from line 29
        waitc(30 * 256 + 100);
        rchk(7'h04, 8'h1e);
        rchk(7'h05, 8'h40);
        rchk(7'h06, 8'h20);
        waitc(120 * 256 + 20);
        rchk(7'h07, 8'h50);
        for (i = 0; i < 4; i++) begin
            rchk(7'(8 + i), 8'(32 * (i + 1)));
        end
        chk("gain held", aGain, 8'h11);
        @(posedge frameStart_q);
        @(negedge clk);
        chk("gain", aGain, 8'h5a);
        chk("clkdiv", aClkDiv, 8'h06);
        chk("fine", aFine, 8'h33);
        chk("coarse", aCoarse, 8'h44);
        rchk(7'h02, 8'h08);
        wrap_up;
    end

    task automatic waitc(input int n);
        while (cyc < n) @(negedge clk);
    endtask
endmodule // tb_ess_stats_top
